// ### inc/pwm_timer_params.svh
// Constants for the six-channel PWM timer
`ifndef PWM_TIMER_PARAMS_SVH
`define PWM_TIMER_PARAMS_SVH
`define CNT_W 16
`define NUM_CH 6
`define PS_W 3
`define PS_EXT 3'h7
`define PS_MAX_SHIFT 3'h6
`define CNT_ZERO 16'h0000
`define CNT_ONE 16'h0001
`define DIV_ZERO 6'h00
`define ELS_CLEAR 2'h2
`define ELS_SET 2'h3
`define ELS_TOGGLE 2'h1
`endif

// ### inc/pwm_timer_pkg.sv
// Types for the six-channel PWM timer
`include "pwm_timer_params.svh"
package pwm_timer_pkg;
  typedef logic [`CNT_W-1:0] count_t;
  typedef logic [`NUM_CH-1:0] chmask_t;
  typedef enum logic [1:0] {
    mode_off = 2'b00,
    mode_single = 2'b01,
    mode_pair = 2'b10
  } ch_mode_e;
endpackage

// ### hdl/tick_divider.sv
// Prescaler producing the counter tick enable
`timescale 1ns/1ps
`default_nettype none
`include "pwm_timer_params.svh"
module tick_divider
  import pwm_timer_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic clear,
  input wire logic [`PS_W-1:0] prescale_select,
  input wire logic external_count_clock,
  output logic tick
);
  typedef struct packed {
    logic [5:0] div;
    logic ext_prev;
  } div_s;
  div_s st;
  div_s next_st;
  logic [5:0] mask;

  always_comb begin
    next_st = st;
    mask = 6'(({6'h00, 1'b1} << prescale_select) - 7'h01);
    tick = 1'b0;
    next_st.ext_prev = external_count_clock;
    if (prescale_select == `PS_EXT) begin
      // Rising edge of the outside clock, taken as synchronous
      tick = external_count_clock & ~st.ext_prev;
    end else begin
      tick = ((st.div & mask) == `DIV_ZERO);
      next_st.div = 6'(st.div + 6'h01);
    end
    if (clear) begin
      next_st.div = `DIV_ZERO;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule
`default_nettype wire

// ### hdl/pwm_timer.sv
// Six-channel 16-bit PWM timer with buffered channel pairs
//
// Overview of operation
// - Toggle enabled pins when counter hits limit.
// - Compare match applies selected pin action.
// - Limit 255 at divide one: 256 clocks.
// - Compare 128 of 256 gives half duty.
// - Even link bit pairs even with odd.
// - Last written set takes over at overflow.
// - Even controls pair; odd pin released.
// - Pair link beats single mode select.
// - No overflow toggle gives zero duty.
// - Full-duty force plus toggle gives 100%.
// - Unbuffered compare value acts at once.
// - Overflow flag set at period limit.
// - Channel flag set on compare.
// - Counter clear zeroes counter and prescaler.
// - Prescale select divides or picks outside clock.
`timescale 1ns/1ps
`default_nettype none
`include "pwm_timer_params.svh"
module pwm_timer
  import pwm_timer_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic counter_halt,
  input wire logic counter_clear,
  input wire logic [`PS_W-1:0] prescale_select,
  input wire logic external_count_clock,
  input wire logic overflow_irq_enable,
  input wire logic overflow_flag_clear,
  input wire count_t period_limit,
  input wire count_t compare_wdata,
  input wire chmask_t compare_write,
  input wire chmask_t pair_link_select,
  input wire chmask_t single_mode_select,
  input wire chmask_t overflow_toggle_enable,
  input wire chmask_t full_duty_force,
  input wire logic [2*`NUM_CH-1:0] edge_level_select,
  input wire chmask_t channel_irq_enable,
  input wire chmask_t channel_flag_clear,
  output count_t counter_value,
  output logic overflow_flag,
  output logic overflow_irq,
  output chmask_t channel_event_flag,
  output logic channel_irq,
  output chmask_t channel_out,
  output chmask_t channel_out_en,
  output logic [2:0] pair_active_odd
);
  typedef struct packed {
    count_t cnt;
    count_t [`NUM_CH-1:0] cmp;
    chmask_t pin;
    logic [2:0] odd_sel;
    logic [2:0] odd_pend;
    logic ovf;
    chmask_t chf;
  } state_s;
  state_s st;
  state_s next_st;
  logic tick;
  logic at_limit;
  logic overflow;
  chmask_t linked;
  count_t active_cmp;
  count_t stepped;
  chmask_t hit;
  ch_mode_e mode;

  tick_divider u_div (
    .core_clk(core_clk),
    .rstn(rstn),
    .clear(counter_clear),
    .prescale_select(prescale_select),
    .external_count_clock(external_count_clock),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Channel mode decode, used for every channel
  function automatic ch_mode_e chan_mode(input logic link_b, input logic single_a);
    if (link_b) begin
      chan_mode = mode_pair;
    end else if (single_a) begin
      chan_mode = mode_single;
    end else begin
      chan_mode = mode_off;
    end
  endfunction

  function automatic logic compare_level(input logic [1:0] els, input logic cur);
    case (els)
      `ELS_CLEAR: compare_level = 1'b0;
      `ELS_SET: compare_level = 1'b1;
      `ELS_TOGGLE: compare_level = ~cur;
      default: compare_level = cur;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st = st;
    active_cmp = `CNT_ZERO;
    mode = mode_off;
    hit = '0;
    at_limit = (st.cnt == period_limit);
    stepped = at_limit ? `CNT_ZERO : count_t'(st.cnt + `CNT_ONE);
    overflow = tick & ~counter_halt & at_limit;
    // Odd channels of a linked pair are slaved to their even partner
    linked = '0;
    for (int p = 0; p < 3; p++) begin
      linked[2*p+1] = pair_link_select[2*p];
    end
    // Counter
    if (tick & ~counter_halt) begin
      next_st.cnt = stepped;
    end
    if (counter_clear) begin
      next_st.cnt = `CNT_ZERO;
    end
    // Compare writes take effect at once
    for (int c = 0; c < `NUM_CH; c++) begin
      if (compare_write[c]) begin
        next_st.cmp[c] = compare_wdata;
      end
    end
    // Track the most recently written set of each pair
    for (int p = 0; p < 3; p++) begin
      if (compare_write[2*p+1]) begin
        next_st.odd_pend[p] = 1'b1;
      end else if (compare_write[2*p]) begin
        next_st.odd_pend[p] = 1'b0;
      end
      if (!pair_link_select[2*p]) begin
        // Unlinked pair restarts on the even set
        next_st.odd_sel[p] = 1'b0;
        next_st.odd_pend[p] = 1'b0;
      end else if (overflow) begin
        next_st.odd_sel[p] = next_st.odd_pend[p];
      end
    end
    // Pin logic; a compare acts as the counter steps onto the compare value,
    // so the pulse lasts exactly the compare value in counts
    for (int c = 0; c < `NUM_CH; c++) begin
      mode = chan_mode(pair_link_select[c] & ~c[0], single_mode_select[c]);
      active_cmp = st.cmp[c];
      // The set chosen at an overflow already governs the period it starts
      if (mode == mode_pair && next_st.odd_sel[c/2]) begin
        active_cmp = st.cmp[c | 1];
      end
      hit[c] = (mode != mode_off) && !linked[c] && tick && !counter_halt && (stepped == active_cmp);
      if (hit[c]) begin
        next_st.chf[c] = 1'b1;
        // Full duty keeps the pulse level, so its compare only raises the flag
        if (!full_duty_force[c]) begin
          next_st.pin[c] = compare_level(edge_level_select[2*c +: 2], st.pin[c]);
        end
      end
      if (mode != mode_off && !linked[c] && overflow && overflow_toggle_enable[c]) begin
        // Max duty keeps the pin at the pulse level across the period
        if (full_duty_force[c]) begin
          next_st.pin[c] = ~compare_level(edge_level_select[2*c +: 2], st.pin[c]);
        end else begin
          next_st.pin[c] = ~st.pin[c];
        end
      end
      // Without overflow toggle the compare level just holds: zero duty
      if (channel_flag_clear[c] && !hit[c]) begin
        // A compare in the clearing cycle wins over the clear
        next_st.chf[c] = 1'b0;
      end
    end
    if (overflow) begin
      next_st.ovf = 1'b1;
    end else if (overflow_flag_clear) begin
      next_st.ovf = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    counter_value = st.cnt;
    overflow_flag = st.ovf;
    overflow_irq = st.ovf & overflow_irq_enable;
    channel_event_flag = st.chf;
    channel_irq = |(st.chf & channel_irq_enable & ~linked);
    channel_out = st.pin;
    pair_active_odd = st.odd_sel;
    for (int c = 0; c < `NUM_CH; c++) begin
      channel_out_en[c] = (pair_link_select[c] & ~c[0]) | single_mode_select[c];
    end
    channel_out_en = channel_out_en & ~linked;
  end
endmodule
`default_nettype wire

// ### dv/pwm_timer_assertions.sv
// Port checker for the PWM timer
`timescale 1ns/1ps
`default_nettype none
module pwm_timer_assertions
  import pwm_timer_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic counter_halt,
  input wire logic counter_clear,
  input wire logic [2:0] prescale_select,
  input wire logic overflow_irq_enable,
  input wire count_t period_limit,
  input wire chmask_t pair_link_select,
  input wire chmask_t overflow_toggle_enable,
  input wire chmask_t full_duty_force,
  input wire logic [11:0] edge_level_select,
  input wire count_t counter_value,
  input wire logic overflow_flag,
  input wire logic overflow_irq,
  input wire chmask_t channel_out,
  input wire chmask_t channel_out_en,
  input wire logic [2:0] pair_active_odd
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////
  // Stepping and wrap are checked at divide-by-one only; slower codes tick less often
  logic run;
  logic at_lim;
  assign run = !counter_halt && !counter_clear && prescale_select == 3'h0;
  assign at_lim = run && counter_value == period_limit;
  chk_wrap_zero: assert property (at_lim |=> counter_value == 16'h0000)
    else $error("no wrap");
  chk_count_step: assert property (run && !at_lim |=> counter_value == $past(counter_value) + 16'h0001)
    else $error("bad step");
  chk_halt_hold: assert property (counter_halt && !counter_clear |=> $stable(counter_value))
    else $error("moved halted");
  chk_clear_zero: assert property (counter_clear |=> counter_value == 16'h0000)
    else $error("no clear");
  chk_ovf_flag: assert property (at_lim |=> overflow_flag)
    else $error("no flag");
  chk_ovf_irq: assert property (overflow_irq == (overflow_flag && overflow_irq_enable))
    else $error("bad irq");
  chk_odd_release: assert property (pair_link_select[0] |-> !channel_out_en[1])
    else $error("odd driven");
  chk_ovf_toggle: assert property (at_lim && overflow_toggle_enable[0] && !full_duty_force[0]
    && channel_out_en[0] |=> channel_out[0] != $past(channel_out[0]))
    else $error("no toggle");
  chk_zero_duty: assert property (!overflow_toggle_enable[2] && edge_level_select[5:4] == 2'h2
    && !channel_out[2] |=> !channel_out[2])
    else $error("zero duty pin rose");
  chk_full_duty: assert property (overflow_toggle_enable[4] && full_duty_force[4]
    && edge_level_select[9:8] == 2'h2 && channel_out[4] |=> channel_out[4])
    else $error("full duty pin fell");
  cover property (pair_active_odd[0]);
  cover property (at_lim);
  cover property ($fell(channel_out[0]));
endmodule
bind pwm_timer pwm_timer_assertions u_pwm_timer_assertions (.*);
`default_nettype wire

// ### dv/pwm_pin_monitor.sv
// Pin monitor measuring PWM period and high time
`timescale 1ns/1ps
`default_nettype none
module pwm_pin_monitor (
  input wire logic core_clk,
  input wire logic pin,
  output logic [15:0] period_len,
  output logic [15:0] high_len
);
  logic prev;
  logic [15:0] cnt;
  logic [15:0] hcnt;
  initial {prev, cnt, hcnt, period_len, high_len} = '0;
  always @(posedge core_clk) begin
    prev <= pin;
    cnt <= (pin && !prev) ? 16'h0001 : cnt + 16'h0001;
    hcnt <= (pin && !prev) ? 16'h0001 : hcnt + {15'h0, pin};
    if (pin && !prev) period_len <= cnt;
    if (!pin && prev) high_len <= hcnt;
  end
endmodule
`default_nettype wire

// ### dv/timer_pwm_channel_generation_bench.sv
// Self-checking bench for the PWM timer
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; $display("ERROR %0t %h %h", $time, a, b); end end
module timer_pwm_channel_generation_bench
  import pwm_timer_pkg::*;
;
  logic core_clk = 0, rstn = 0, counter_halt = 1, counter_clear = 0, external_count_clock = 0;
  logic overflow_irq_enable = 0, overflow_flag_clear = 0, overflow_flag, overflow_irq, channel_irq;
  logic [2:0] prescale_select = 3'h0;
  logic [2:0] pair_active_odd;
  logic [11:0] edge_level_select = 12'h000;
  logic [15:0] period_len, high_len;
  count_t period_limit = '0, compare_wdata = '0, counter_value;
  chmask_t compare_write = '0, pair_link_select = '0, single_mode_select = '0, overflow_toggle_enable = '0;
  chmask_t full_duty_force = '0, channel_irq_enable = '0, channel_flag_clear = '0;
  chmask_t channel_event_flag, channel_out, channel_out_en;
  int failures = 0, num_checks = 0;
  pwm_timer u_pwm_timer (
    .core_clk(core_clk),
    .rstn(rstn),
    .counter_halt(counter_halt),
    .counter_clear(counter_clear),
    .prescale_select(prescale_select),
    .external_count_clock(external_count_clock),
    .overflow_irq_enable(overflow_irq_enable),
    .overflow_flag_clear(overflow_flag_clear),
    .period_limit(period_limit),
    .compare_wdata(compare_wdata),
    .compare_write(compare_write),
    .pair_link_select(pair_link_select),
    .single_mode_select(single_mode_select),
    .overflow_toggle_enable(overflow_toggle_enable),
    .full_duty_force(full_duty_force),
    .edge_level_select(edge_level_select),
    .channel_irq_enable(channel_irq_enable),
    .channel_flag_clear(channel_flag_clear),
    .counter_value(counter_value),
    .overflow_flag(overflow_flag),
    .overflow_irq(overflow_irq),
    .channel_event_flag(channel_event_flag),
    .channel_irq(channel_irq),
    .channel_out(channel_out),
    .channel_out_en(channel_out_en),
    .pair_active_odd(pair_active_odd)
  );
  pwm_pin_monitor u_pwm_pin_monitor (.core_clk(core_clk), .pin(channel_out[0]), .period_len(period_len),
    .high_len(high_len));
  initial forever #12.5 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////
  task stop_test;
    if (failures == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask
  // Idle cycle after the strobe so back-to-back writes never merge
  task wcmp(input int ch, input count_t v);
    compare_wdata = v;
    compare_write = chmask_t'(1 << ch);
    cyc(1);
    compare_write = '0;
    cyc(1);
  endtask
  // Halt first so the new limit never meets a running count
  task setup(input count_t lim);
    counter_halt = 1;
    counter_clear = 1;
    cyc(1);
    counter_clear = 0;
    period_limit = lim;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    cyc(4);
    rstn = 1;
    setup(16'h00ff);
    wcmp(0, 16'h0080);
    single_mode_select = 6'h01;
    overflow_toggle_enable = 6'h01;
    edge_level_select = 12'h002;
    overflow_irq_enable = 1;
    channel_irq_enable = 6'h01;
    counter_halt = 0;
    cyc(800);
    `CHK(period_len, 16'h0100)
    `CHK(high_len, 16'h0080)
    `CHK(overflow_irq, 1'b1)
    `CHK(channel_irq, 1'b1)
    overflow_flag_clear = 1;
    channel_flag_clear = 6'h01;
    cyc(1);
    overflow_flag_clear = 0;
    channel_flag_clear = '0;
    `CHK({overflow_flag, channel_event_flag[0]}, 2'b00)
    setup(16'h000f);
    wcmp(0, 16'h0004);
    wcmp(4, 16'h0008);
    pair_link_select = 6'h01;
    single_mode_select = 6'h17;
    overflow_toggle_enable = 6'h11;
    full_duty_force = 6'h10;
    edge_level_select = 12'h222;
    counter_halt = 0;
    cyc(40);
    `CHK(high_len, 16'h0004)
    `CHK(channel_out_en[1], 1'b0)
    `CHK({channel_out[4], channel_out[2]}, 2'b10)
    wcmp(1, 16'h000a);
    cyc(40);
    `CHK(pair_active_odd, 3'h1)
    `CHK(high_len, 16'h000a)
    // Unbuffered again: lengthen at overflow, shorten at compare
    pair_link_select = '0;
    overflow_flag_clear = 1;
    cyc(1);
    overflow_flag_clear = 0;
    while (!overflow_flag) cyc(1);
    wcmp(0, 16'h000c);
    cyc(40);
    `CHK(high_len, 16'h000c)
    channel_flag_clear = 6'h01;
    cyc(1);
    channel_flag_clear = '0;
    while (!channel_event_flag[0]) cyc(1);
    wcmp(0, 16'h0006);
    cyc(40);
    `CHK(high_len, 16'h0006)
    prescale_select = 3'h1;
    cyc(80);
    `CHK(period_len, 16'h0020)
    `CHK(high_len, 16'h000c)
    prescale_select = 3'h7;
    repeat (100) begin
      external_count_clock = ~external_count_clock;
      cyc(2);
    end
    `CHK(period_len, 16'h0040)
    `CHK(high_len, 16'h0018)
    stop_test;
  end
  initial begin
    #60000;
    failures++;
    stop_test;
  end
endmodule
`default_nettype wire
